// [verilog/can_rx_buffers.sv]
// Purpose : Sixteen receive buffers with filters, dispatch, chaining and replies
// Assumes : Frames arrive as one-cycle strobes, software uses the register port
// Notes   : Read data appears one cycle after reg_rd_i
// Notes on behaviour
// - Extended transmit sets format bit to one
// - Extended identifier sits in bits 31 to 3
// - Sixteen buffers, every filter compared in parallel
// - Store sets flag; software clears to empty
// - Scan upward for enabled, matching buffer
// - Empty valid buffer stores and flags message
// - Interrupt-enabled store raises message event
// - Full unchained buffer: overrun, overwrite message
// - Mask zero compares bit, one ignores
// - Compare identifier, format, remote, two bytes
// - Standard identifier compared in bits 31-21
// - Data filter checks unmasked first-two-byte bits
// - Extended acceptance needs format bit set
// - Full chained buffer continues; none left: overrun
// - Arrays chain all but last, same filters
// - Remote frame has no data field
// - Enabled auto answer replies to remote frame
// - Format guard low blocks bits 21-16
// - Pending set on request, cleared, cancellable
// - Replies wait for current queued transmission
`default_nettype none
module can_rx_buffers
	import can_rx_pkg::*;
#(
	parameter int N_BUF = NUM_RX_BUF
)(
	input  wire logic        clock_i,         // 100 MHz clock
	input  wire logic        nrst_i,          // Async reset, active low
	can_link_if.dev          link,            // Bus-side frames and replies
	input  wire logic        reg_wr_i,        // Register write strobe
	input  wire logic        reg_rd_i,        // Register read strobe
	input  wire logic [3:0]  reg_buf_i,       // Buffer index
	input  wire logic [2:0]  reg_sel_i,       // Register select
	input  wire logic [31:0] reg_wdata_i,     // Write data
	output logic      [31:0] reg_rdata_o,     // Read data, registered
	input  wire logic        tx_busy_i,       // Queued transmission in progress
	output logic      [15:0] buffer_status_o, // Message available per buffer
	output logic             rx_message_event_event_o,  // rx_message_event pulse
	output logic             rx_ovr_event_o   // rx_overrun_event pulse
);
	typedef enum logic [0:0] {
		ANS_IDLE = 1'b0,
		ANS_SEND = 1'b1
	} ans_state_t;

	// ==========================================================
	// Storage
	logic [31:0] id_ff    [N_BUF];
	logic [63:0] data_ff  [N_BUF];
	logic [31:0] fmask_ff [N_BUF];
	logic [31:0] fcode_ff [N_BUF];
	logic [31:0] dfilt_ff [N_BUF];
	logic [5:0]  fmt_ff   [N_BUF]; // RTR, IDE, DLC
	logic [N_BUF-1:0] av_ff, en_ff, chain_ff, rxie_ff, ans_en_ff, pend_ff;
	logic [N_BUF-1:0] hit, valid;
	ans_state_t       ans_ff;
	logic [3:0]       ans_idx_ff;
	logic [31:0]      rdata_ff;
	logic             msg_ev_ff, ovr_ev_ff;

	// ==========================================================
	// Dispatch decision
	logic             do_store, do_ovr;
	logic [3:0]       tgt;
	logic             wr_cmd, cancel_wr, ans_done;

	// Scan from buffer zero: returns {store, overrun, index}
	function automatic logic [5:0] dispatch(input logic [N_BUF-1:0] v, f, c);
		logic       seek;
		logic       chained;
		logic [5:0] r;
		seek    = 1'b1;
		chained = 1'b0;
		r       = 6'h00;
		for (int i = 0; i < N_BUF; i++) begin
			if (seek && v[i]) begin
				if (!f[i]) begin
					r    = {2'b10, i[3:0]};
					seek = 1'b0;
				end else if (!c[i]) begin
					r    = {2'b11, i[3:0]};
					seek = 1'b0;
				end else begin
					chained = 1'b1;
				end
			end
		end
		if (seek && chained) begin
			r = {2'b01, 4'h0};
		end
		return r;
	endfunction

	// One filter per buffer, all looking at the same frame
	for (genvar g = 0; g < N_BUF; g++) begin : g_flt
		rx_accept_filter rx_accept_filter_inst (
			.id_i    (link.frm_id),
			.ide_i   (link.frm_ide),
			.rtr_i   (link.frm_rtr),
			.data_i  (link.frm_data[63:48]),
			.mask_i  (fmask_ff[g]),
			.code_i  (fcode_ff[g]),
			.dmask_i (dfilt_ff[g][31:16]),
			.dcode_i (dfilt_ff[g][15:0]),
			.hit_o   (hit[g])
		);
	end

	// Decision for the current strobe
	always_comb begin
		valid    = en_ff & hit;
		{do_store, do_ovr, tgt} = dispatch(valid, av_ff, chain_ff);
		do_store = do_store & link.frm_valid;
		do_ovr   = do_ovr & link.frm_valid;
		wr_cmd   = reg_wr_i && (reg_sel_i == SEL_CMD);
		cancel_wr = wr_cmd && reg_wdata_i[CMD_ANS_CANCEL];
		ans_done = link.rep_valid && link.rep_ready;
	end

	// ==========================================================
	// Message contents; a store wins over a software write
	always_ff @(posedge clock_i) begin
		for (int i = 0; i < N_BUF; i++) begin
			if (do_store && tgt == i[3:0]) begin
				id_ff[i]  <= link.frm_id;
				fmt_ff[i] <= {link.frm_rtr, link.frm_ide, link.frm_dlc};
				if (!link.frm_rtr) begin
					data_ff[i] <= link.frm_data;
				end
			end else if (reg_wr_i && reg_buf_i == i[3:0]) begin
				case (reg_sel_i)
					SEL_ID:  id_ff[i] <= {reg_wdata_i[31:3], 3'b000};
					SEL_DH:  data_ff[i][63:32] <= reg_wdata_i;
					SEL_DL:  data_ff[i][31:0] <= reg_wdata_i;
					SEL_CMD: begin
						if (reg_wdata_i[CMD_FMT_GUARD]) begin
							fmt_ff[i] <= reg_wdata_i[21:16];
						end
					end
					default: ;
				endcase
			end
		end
	end

	// Filter settings, software only
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (int i = 0; i < N_BUF; i++) begin
				fmask_ff[i] <= RST_WORD;
				fcode_ff[i] <= RST_WORD;
				dfilt_ff[i] <= RST_WORD;
			end
		end else if (reg_wr_i) begin
			case (reg_sel_i)
				SEL_FMASK: fmask_ff[reg_buf_i] <= reg_wdata_i;
				SEL_FCODE: fcode_ff[reg_buf_i] <= reg_wdata_i;
				SEL_DFILT: dfilt_ff[reg_buf_i] <= reg_wdata_i;
				default:   ;
			endcase
		end
	end

	// ==========================================================
	// Control bits, protected by the control guard
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			en_ff     <= RST_HALF;
			chain_ff  <= RST_HALF;
			rxie_ff   <= RST_HALF;
			ans_en_ff <= RST_HALF;
		end else if (wr_cmd && reg_wdata_i[CMD_CTL_GUARD]) begin
			en_ff[reg_buf_i]     <= reg_wdata_i[CMD_BUF_EN];
			chain_ff[reg_buf_i]  <= reg_wdata_i[CMD_CHAIN];
			rxie_ff[reg_buf_i]   <= reg_wdata_i[CMD_RXIE];
			ans_en_ff[reg_buf_i] <= reg_wdata_i[CMD_ANS_EN];
		end
	end

	// Message available: write one clears, a store in the same cycle wins
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			av_ff <= RST_HALF;
		end else begin
			for (int i = 0; i < N_BUF; i++) begin
				if (do_store && tgt == i[3:0]) begin
					av_ff[i] <= 1'b1;
				end else if (wr_cmd && reg_buf_i == i[3:0] && reg_wdata_i[CMD_MESSAGE_AVAILABLE_FLAG]) begin
					av_ff[i] <= 1'b0;
				end
			end
		end
	end

	// Reply pending: set by accepted remote frame when auto answer is enabled, cleared by send, disable or cancel
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pend_ff <= RST_HALF;
		end else begin
			for (int i = 0; i < N_BUF; i++) begin
				if (do_store && tgt == i[3:0] && link.frm_rtr && ans_en_ff[i]) begin
					pend_ff[i] <= 1'b1;
				end else if (!en_ff[i] || (cancel_wr && reg_buf_i == i[3:0])
					|| (ans_done && ans_idx_ff == i[3:0])) begin
					pend_ff[i] <= 1'b0;
				end
			end
		end
	end

	// ==========================================================
	// Automatic reply sequencer
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ans_ff     <= ANS_IDLE;
			ans_idx_ff <= 4'h0;
		end else begin
			case (ans_ff)
				ANS_IDLE: begin
					if (|pend_ff && !tx_busy_i) begin
						ans_ff <= ANS_SEND;
						for (int i = N_BUF - 1; i >= 0; i--) begin
							if (pend_ff[i]) begin
								ans_idx_ff <= i[3:0];
							end
						end
					end
				end
				ANS_SEND: begin
					if (ans_done || !pend_ff[ans_idx_ff]) begin
						ans_ff <= ANS_IDLE;
					end
				end
				default: ans_ff <= ANS_IDLE;
			endcase
		end
	end

	// Reply word taken from the answering buffer
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			link.rep_id   <= RST_WORD;
			link.rep_ide  <= 1'b0;
			link.rep_dlc  <= 4'h0;
			link.rep_data <= {RST_WORD, RST_WORD};
		end else if (ans_ff == ANS_SEND) begin
			link.rep_id   <= id_ff[ans_idx_ff];
			link.rep_ide  <= fmt_ff[ans_idx_ff][4];
			link.rep_dlc  <= fmt_ff[ans_idx_ff][3:0];
			link.rep_data <= data_ff[ans_idx_ff];
		end
	end

	// Offer waits one cycle so the reply word is loaded
	logic offer_ff;
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			offer_ff <= 1'b0;
		end else begin
			offer_ff <= (ans_ff == ANS_SEND) && !ans_done && pend_ff[ans_idx_ff];
		end
	end
	assign link.rep_valid = offer_ff && (ans_ff == ANS_SEND) && pend_ff[ans_idx_ff];

	// ==========================================================
	// Events and readback
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			msg_ev_ff <= 1'b0;
			ovr_ev_ff <= 1'b0;
			rdata_ff  <= RST_WORD;
		end else begin
			msg_ev_ff <= do_store && rxie_ff[tgt];
			ovr_ev_ff <= do_ovr;
			if (reg_rd_i) begin
				case (reg_sel_i)
					SEL_CMD:   rdata_ff <= {10'h000, fmt_ff[reg_buf_i], 9'h000,
						chain_ff[reg_buf_i], rxie_ff[reg_buf_i], ans_en_ff[reg_buf_i],
						en_ff[reg_buf_i], 1'b0, pend_ff[reg_buf_i], av_ff[reg_buf_i]};
					SEL_ID:    rdata_ff <= id_ff[reg_buf_i];
					SEL_DH:    rdata_ff <= data_ff[reg_buf_i][63:32];
					SEL_DL:    rdata_ff <= data_ff[reg_buf_i][31:0];
					SEL_FMASK: rdata_ff <= fmask_ff[reg_buf_i];
					SEL_FCODE: rdata_ff <= fcode_ff[reg_buf_i];
					SEL_DFILT: rdata_ff <= dfilt_ff[reg_buf_i];
					default:   rdata_ff <= RST_WORD;
				endcase
			end
		end
	end

	assign reg_rdata_o     = rdata_ff;
	assign buffer_status_o = av_ff;
	assign rx_message_event_event_o  = msg_ev_ff;
	assign rx_ovr_event_o  = ovr_ev_ff;
endmodule
`default_nettype wire

// [verilog/can_rx_pkg.sv]
// Purpose : Shared constants for the receive buffer block and its link partner
// Assumes : Single 100 MHz clock, frames arrive as whole words on the link
// Notes   : Register select codes, command bit positions and filter layout
`default_nettype none
package can_rx_pkg;
	// ==========================================================
	// Sizes
	localparam int NUM_RX_BUF = 16;
	localparam int IDX_W      = 4;
	// ==========================================================
	// Register select codes on the software port
	localparam logic [2:0] SEL_CMD   = 3'h0; // rx_buffer_command
	localparam logic [2:0] SEL_ID    = 3'h1; // rx_buffer_identifier
	localparam logic [2:0] SEL_DH    = 3'h2; // rx_buffer_data_high
	localparam logic [2:0] SEL_DL    = 3'h3; // rx_buffer_data_low
	localparam logic [2:0] SEL_FMASK = 3'h4; // filter_mask
	localparam logic [2:0] SEL_FCODE = 3'h5; // filter_code
	localparam logic [2:0] SEL_DFILT = 3'h6; // data mask [31:16], data code [15:0]
	// ==========================================================
	// Command register bit positions
	localparam int CMD_FMT_GUARD = 23;
	localparam int CMD_RTR       = 21;
	localparam int CMD_IDE       = 20;
	localparam int CMD_DLC_HI    = 19;
	localparam int CMD_DLC_LO    = 16;
	localparam int CMD_CTL_GUARD = 7;
	localparam int CMD_CHAIN     = 6;
	localparam int CMD_RXIE      = 5;
	localparam int CMD_ANS_EN    = 4;
	localparam int CMD_BUF_EN    = 3;
	localparam int CMD_ANS_CANCEL = 2;
	localparam int CMD_ANS_PEND  = 1;
	localparam int CMD_MESSAGE_AVAILABLE_FLAG    = 0;
	// ==========================================================
	// Filter word layout: ID [31:3], IDE [2], RTR [1], bit 0 unused
	localparam int FLT_IDE = 2;
	localparam int FLT_RTR = 1;
	localparam logic [31:0] STD_IGNORE   = 32'h001F_FFF9; // Extended ID bits and bit 0
	localparam logic [31:0] EXT_IGNORE   = 32'h0000_0001;
	localparam logic [31:0] ID_STD_SHIFT = 32'h0000_0015; // 21
	localparam logic [31:0] ID_EXT_SHIFT = 32'h0000_0003; // 3
	// ==========================================================
	// Reset values
	localparam logic [31:0] RST_WORD  = 32'h0000_0000;
	localparam logic [15:0] RST_HALF  = 16'h0000;
endpackage
`default_nettype wire

// [verilog/can_link_if.sv]
// Purpose : Joins the receive buffer block to the far node on the bus side
// Assumes : Both ends on clock_i; frame is a one-cycle strobe, reply handshakes
// Notes   : Identifier travels in register layout, ID in [31:3]
`default_nettype none
interface can_link_if;
	logic        frm_valid; // Frame strobe from far node
	logic [31:0] frm_id;    // Identifier, register layout
	logic        frm_ide;   // Extended format when high
	logic        frm_rtr;   // Remote frame when high
	logic [3:0]  frm_dlc;   // Length code
	logic [63:0] frm_data;  // D0 in [63:56]
	logic        rep_valid; // Automatic reply offered
	logic        rep_ready; // Far node takes the reply
	logic [31:0] rep_id;
	logic        rep_ide;
	logic [3:0]  rep_dlc;
	logic [63:0] rep_data;
	modport dev (input frm_valid, frm_id, frm_ide, frm_rtr, frm_dlc, frm_data, rep_ready,
		output rep_valid, rep_id, rep_ide, rep_dlc, rep_data);
	modport node (output frm_valid, frm_id, frm_ide, frm_rtr, frm_dlc, frm_data, rep_ready,
		input rep_valid, rep_id, rep_ide, rep_dlc, rep_data);
endinterface
`default_nettype wire

// [verilog/rx_accept_filter.sv]
// Purpose : One acceptance filter: identifier, format, remote and two data bytes
// Assumes : Mask bit one means ignore, zero means must equal the code bit
// Notes   : Purely combinational, one instance per buffer
`default_nettype none
module rx_accept_filter
	import can_rx_pkg::*;
(
	input  wire logic [31:0] id_i,    // Incoming identifier
	input  wire logic        ide_i,   // Incoming format bit
	input  wire logic        rtr_i,   // Incoming remote bit
	input  wire logic [15:0] data_i,  // First two data bytes
	input  wire logic [31:0] mask_i,  // filter_mask
	input  wire logic [31:0] code_i,  // filter_code
	input  wire logic [15:0] dmask_i, // data_filter_mask
	input  wire logic [15:0] dcode_i, // data_filter_code
	output logic             hit_o    // Frame accepted
);
	logic [31:0] vec;
	logic [31:0] eff_mask;
	logic [15:0] eff_dmask;

	// Build compare word and widen mask for short identifiers and remote frames
	always_comb begin
		vec          = {id_i[31:3], ide_i, rtr_i, 1'b0};
		eff_mask     = mask_i | (ide_i ? EXT_IGNORE : STD_IGNORE);
		eff_dmask    = rtr_i ? 16'hFFFF : dmask_i;
		hit_o        = (&(eff_mask | ~(vec ^ code_i)))
			& (&(eff_dmask | ~(data_i ^ dcode_i)));
	end
endmodule
`default_nettype wire

// [verilog/can_far_node.sv]
// Purpose : Far node: puts frames on the link and takes automatic replies
// Assumes : Same clock as the buffer block
// Notes   : Identifier is placed in register layout before sending
`default_nettype none
module can_far_node
	import can_rx_pkg::*;
(
	input  wire logic        clock_i,   // 100 MHz clock
	input  wire logic        nrst_i,    // Async reset, active low
	can_link_if.node         link,      // Link to the buffer block
	input  wire logic        send_i,    // Send one frame, pulse
	input  wire logic        ext_i,     // Extended format
	input  wire logic        rtr_i,     // Remote frame
	input  wire logic [28:0] id_i,      // Identifier, right aligned
	input  wire logic [3:0]  dlc_i,     // Length code
	input  wire logic [63:0] data_i,    // Payload, D0 in [63:56]
	input  wire logic        take_i,    // Ready to take a reply
	output logic             got_o,     // Reply taken, pulse
	output logic      [31:0] got_id_o,  // Reply identifier
	output logic      [63:0] got_data_o // Reply payload
);
	// ==========================================================
	// Frame launch
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			link.frm_valid <= 1'b0;
			link.frm_id    <= RST_WORD;
			link.frm_ide   <= 1'b0;
			link.frm_rtr   <= 1'b0;
			link.frm_dlc   <= 4'h0;
			link.frm_data  <= {RST_WORD, RST_WORD};
		end else begin
			link.frm_valid <= send_i;
			if (send_i) begin
				link.frm_ide  <= ext_i;
				link.frm_id   <= ext_i ? ({3'b000, id_i} << ID_EXT_SHIFT)
					: ({21'h0, id_i[10:0]} << ID_STD_SHIFT);
				link.frm_rtr  <= rtr_i;
				link.frm_dlc  <= dlc_i;
				link.frm_data <= rtr_i ? {RST_WORD, RST_WORD} : data_i;
			end
		end
	end

	assign link.rep_ready = take_i;

	// Reply capture
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			got_o      <= 1'b0;
			got_id_o   <= RST_WORD;
			got_data_o <= {RST_WORD, RST_WORD};
		end else begin
			got_o <= link.rep_valid && take_i;
			if (link.rep_valid && take_i) begin
				got_id_o   <= link.rep_id;
				got_data_o <= link.rep_data;
			end
		end
	end
endmodule
`default_nettype wire

// [verif/can_link_sva.sv]
// Purpose : Watches the link between the buffer block and the far node
// Assumes : One clock, reset active low, reply identifier and format come from the stored request
// Notes   : Counters pair remote requests with finished replies
`default_nettype none
module can_link_sva (
	input wire logic        clock_i,   // Shared clock
	input wire logic        nrst_i,    // Async reset, active low
	input wire logic        frm_valid, // Frame strobe
	input wire logic [31:0] frm_id,    // Frame identifier
	input wire logic        frm_ide,   // Frame format
	input wire logic        frm_rtr,   // Remote frame
	input wire logic        rep_valid, // Reply offered
	input wire logic        rep_ready, // Reply taken
	input wire logic [31:0] rep_id,    // Reply identifier
	input wire logic        rep_ide,   // Reply format
	input wire logic [3:0]  rep_dlc,   // Reply length
	input wire logic [63:0] rep_data   // Reply payload
);
	logic [31:0] req_id_ff;
	logic        req_ide_ff;
	logic [7:0]  req_cnt_ff;
	logic [7:0]  done_cnt_ff;
	default clocking @(posedge clock_i); endclocking
	default disable iff (!nrst_i);
	// ==========================================
	// Last remote request seen on the link
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			req_id_ff  <= 32'h0000_0000;
			req_ide_ff <= 1'b0;
		end else if (frm_valid && frm_rtr) begin
			req_id_ff  <= frm_id;
			req_ide_ff <= frm_ide;
		end
	end
	// Requests and finished replies since reset
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			req_cnt_ff  <= 8'h00;
			done_cnt_ff <= 8'h00;
		end else begin
			req_cnt_ff  <= req_cnt_ff + 8'((frm_valid && frm_rtr) ? 1 : 0);
			done_cnt_ff <= done_cnt_ff + 8'((rep_valid && rep_ready) ? 1 : 0);
		end
	end
	// ==========================================
	// Reply handshake and content
	chk_rep_hold_id: assert property (rep_valid && !rep_ready |=> !rep_valid || ($stable(rep_id) && $stable(rep_ide)))
		else $error("Reply identifier changed while offered");
	chk_rep_hold_data: assert property (rep_valid && !rep_ready ##1 rep_valid |-> $stable(rep_data) && $stable(rep_dlc))
		else $error("Reply payload changed while offered");
	chk_rep_release: assert property (rep_valid && rep_ready |=> !rep_valid)
		else $error("Reply still offered after it was taken");
	chk_rep_caused: assert property (rep_valid |-> done_cnt_ff < req_cnt_ff)
		else $error("Reply offered without a remote request");
	chk_rep_same_id: assert property ($rose(rep_valid) |-> rep_id[31:3] == req_id_ff[31:3])
		else $error("Reply identifier differs from request");
	chk_rep_same_fmt: assert property ($rose(rep_valid) |-> rep_ide == req_ide_ff)
		else $error("Reply format differs from request");
	chk_rep_not_early: assert property (frm_valid && frm_rtr && !rep_valid |=> !rep_valid)
		else $error("Reply offered in the cycle after the request");
	chk_rep_count_ok: assert property (rep_valid && rep_ready |=> done_cnt_ff <= req_cnt_ff)
		else $error("More replies than remote requests");
	cover property (rep_valid && !rep_ready ##1 rep_valid);
endmodule
`default_nettype wire

// [verif/can_rx_buffer_filtering_tb.sv]
// Purpose : Self-checking bench for the buffer block and the far node
// Assumes : Reads answer next cycle, events one cycle after a taken frame
// Notes   : Drivers queue expectations, monitors pop them as results show
`default_nettype none
module can_rx_buffer_filtering_tb import can_rx_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock_i, nrst_i, reg_wr_i, reg_rd_i, tx_busy_i, send_i, ext_i, rtr_i, take_i;
	logic        rx_message_event_event_o, rx_ovr_event_o, got_o, rd_pend, ev_pend, ok;
	logic [3:0]  reg_buf_i, dlc_i;
	logic [2:0]  reg_sel_i;
	logic [31:0] reg_wdata_i, reg_rdata_o, got_id_o, r;
	logic [15:0] buffer_status_o, exp_st, dd;
	logic [10:0] sid;
	logic [28:0] id_i, eid;
	logic [63:0] data_i, got_data_o;
	logic [95:0] rdq[$];
	logic [17:0] evq[$];
	logic [95:0] repq[$];
	int          num_errors, cmp_count, seed, k;
	// ==========================================
	// Design, far node and link checker
	can_link_if link_if ();
	can_rx_buffers #(.N_BUF(NUM_RX_BUF)) can_rx_buffers_inst (.clock_i(clock_i), .nrst_i(nrst_i), .link(link_if),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_buf_i(reg_buf_i), .reg_sel_i(reg_sel_i),
		.reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .tx_busy_i(tx_busy_i), .buffer_status_o(buffer_status_o),
		.rx_message_event_event_o(rx_message_event_event_o), .rx_ovr_event_o(rx_ovr_event_o));
	can_far_node can_far_node_inst (.clock_i(clock_i), .nrst_i(nrst_i), .link(link_if), .send_i(send_i),
		.ext_i(ext_i), .rtr_i(rtr_i), .id_i(id_i), .dlc_i(dlc_i), .data_i(data_i), .take_i(take_i),
		.got_o(got_o), .got_id_o(got_id_o), .got_data_o(got_data_o));
	can_link_sva can_link_sva_inst (.clock_i(clock_i), .nrst_i(nrst_i), .frm_valid(link_if.frm_valid),
		.frm_id(link_if.frm_id), .frm_ide(link_if.frm_ide), .frm_rtr(link_if.frm_rtr), .rep_valid(link_if.rep_valid),
		.rep_ready(link_if.rep_ready), .rep_id(link_if.rep_id), .rep_ide(link_if.rep_ide),
		.rep_dlc(link_if.rep_dlc), .rep_data(link_if.rep_data));
	// ==========================================
	// Clock and compare tasks
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end
	task automatic chk_val(input logic [95:0] e, input logic [95:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic chk_rep(input logic [95:0] e, input logic [95:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic chk_ev(input logic [17:0] e, input logic [17:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic end_of_test;
		$display("Compares %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// ==========================================
	// Register and frame drivers
	task automatic wr(input logic [3:0] b, input logic [2:0] s, input logic [31:0] d);
		@(negedge clock_i);
		reg_wr_i = 1'b1;
		reg_buf_i = b;
		reg_sel_i = s;
		reg_wdata_i = d;
		@(negedge clock_i);
		reg_wr_i = 1'b0;
	endtask
	task automatic rd(input logic [3:0] b, input logic [2:0] s, input logic [31:0] e);
		@(negedge clock_i);
		reg_rd_i = 1'b1;
		reg_buf_i = b;
		reg_sel_i = s;
		rdq.push_back({64'h0, e});
		@(negedge clock_i);
		reg_rd_i = 1'b0;
	endtask
	task automatic clr(input logic [3:0] b);
		wr(b, SEL_CMD, 32'h0000_0001);
		exp_st[b] = 1'b0;
	endtask
	task automatic frm(input logic e, input logic rm, input logic [28:0] id, input logic [63:0] d, input int sb,
		input logic m, input logic o);
		@(negedge clock_i);
		send_i = 1'b1;
		ext_i = e;
		rtr_i = rm;
		id_i = id;
		dlc_i = rm ? 4'h4 : 4'h8;
		data_i = d;
		@(negedge clock_i);
		send_i = 1'b0;
		if (sb >= 0) exp_st[sb[3:0]] = 1'b1;
		evq.push_back({exp_st, m, o});
		repeat (2) @(negedge clock_i);
	endtask
	// ==========================================
	// Result monitors
	always @(posedge clock_i) begin
		rd_pend <= reg_rd_i;
		ev_pend <= link_if.frm_valid;
	end
	always @(negedge clock_i) begin
		if (rd_pend === 1'b1) chk_val(rdq.size() > 0 ? rdq.pop_front() : 'x, {64'h0, reg_rdata_o});
		if (ev_pend === 1'b1) chk_ev(evq.size() > 0 ? evq.pop_front() : 'x, {buffer_status_o, rx_message_event_event_o, rx_ovr_event_o});
		else if ({rx_message_event_event_o, rx_ovr_event_o} !== 2'b00) chk_ev('x, {buffer_status_o, rx_message_event_event_o, rx_ovr_event_o});
		if (got_o === 1'b1) chk_rep(repq.size() > 0 ? repq.pop_front() : 'x, {got_id_o, got_data_o});
	end
	initial begin
		#100us;
		chk_val(96'h1, 96'h0);
		end_of_test();
	end
	// ==========================================
	// Main sequence
	initial begin
		{reg_wr_i, reg_rd_i, tx_busy_i, send_i, ext_i, rtr_i} = 6'h00;
		{reg_buf_i, dlc_i, reg_sel_i, reg_wdata_i, id_i, data_i} = '0;
		take_i = 1'b1;
		exp_st = 16'h0000;
		seed = 32'h93dd;
		nrst_i = 1'b0;
		repeat (12) @(negedge clock_i);
		nrst_i = 1'b1;
		wr(4'hF, SEL_CMD, 32'h0080_0000);
		wr(4'hF, SEL_CMD, 32'h003F_0000);
		rd(4'hF, SEL_CMD, 32'h0000_0000);
		wr(4'hF, SEL_CMD, 32'h00BF_0008);
		rd(4'hF, SEL_CMD, 32'h003F_0000);
		rd(4'h0, 3'h7, 32'h0000_0000);
		$display("Guard test done");
		wr(4'h1, SEL_CMD, 32'h0000_0088);
		wr(4'h3, SEL_FMASK, 32'h601F_FFF9);
		wr(4'h3, SEL_FCODE, 32'h0640_0000);
		wr(4'h3, SEL_DFILT, 32'h063F_0180);
		wr(4'h3, SEL_CMD, 32'h0000_00A8);
		for (k = 0; k < 24; k++) begin
			r = $random(seed);
			sid = 11'h032 ^ (r[10:0] & 11'h303);
			dd = 16'h0180 ^ (r[31:16] & 16'h863F);
			ok = ((sid ^ 11'h032) & 11'h4FF) == 11'h000 && ((dd ^ 16'h0180) & 16'hF9C0) == 16'h0000;
			frm(1'b0, 1'b0, {18'h0, sid}, {dd, r, 16'h5A5A}, ok ? 3 : -1, ok, 1'b0);
			if (ok) begin
				rd(4'h3, SEL_ID, {sid, 21'h0});
				clr(4'h3);
			end
		end
		$display("Filter test done");
		eid = 29'($random(seed));
		wr(4'h5, SEL_FMASK, 32'h0000_0001);
		wr(4'h5, SEL_FCODE, {eid, 3'b100});
		wr(4'h5, SEL_DFILT, 32'hFFFF_0000);
		wr(4'h5, SEL_CMD, 32'h0000_00A8);
		frm(1'b1, 1'b0, eid, 64'h0102_0304_0506_0708, 5, 1'b1, 1'b0);
		rd(4'h5, SEL_ID, {eid, 3'b000});
		rd(4'h5, SEL_CMD, 32'h0018_0029);
		$display("Extended test done");
		for (k = 8; k < 10; k++) begin
			wr(k[3:0], SEL_FMASK, STD_IGNORE);
			wr(k[3:0], SEL_FCODE, 32'h2000_0000);
			wr(k[3:0], SEL_DFILT, 32'hFFFF_0000);
		end
		wr(4'h8, SEL_CMD, 32'h0000_00E8);
		wr(4'h9, SEL_CMD, 32'h0000_0088);
		frm(1'b0, 1'b0, 29'h100, 64'hC1C1_0001_0000_0001, 8, 1'b1, 1'b0);
		frm(1'b0, 1'b0, 29'h100, 64'hC2C2_0002_0000_0002, 9, 1'b0, 1'b0);
		frm(1'b0, 1'b0, 29'h100, 64'hC3C3_0003_0000_0003, 9, 1'b0, 1'b1);
		rd(4'h9, SEL_DH, 32'hC3C3_0003);
		wr(4'h9, SEL_CMD, 32'h0000_00C8);
		frm(1'b0, 1'b0, 29'h100, 64'hC4C4_0004_0000_0004, -1, 1'b0, 1'b1);
		rd(4'h9, SEL_DH, 32'hC3C3_0003);
		clr(4'h8);
		frm(1'b0, 1'b0, 29'h100, 64'hC5C5_0005_0000_0005, 8, 1'b1, 1'b0);
		$display("Chain test done");
		wr(4'hC, SEL_FMASK, 32'h001F_FFFB);
		wr(4'hC, SEL_FCODE, 32'h54A0_0000);
		wr(4'hC, SEL_DH, 32'hFEED_0001);
		wr(4'hC, SEL_DL, 32'hFEED_0002);
		wr(4'hC, SEL_CMD, 32'h0000_0098);
		tx_busy_i = 1'b1;
		take_i = 1'b0;
		frm(1'b0, 1'b1, 29'h2A5, 64'hDEAD_DEAD_DEAD_DEAD, 12, 1'b0, 1'b0);
		repeat (10) @(negedge clock_i);
		rd(4'hC, SEL_CMD, 32'h0024_001B);
		repq.push_back({32'h54A0_0000, 64'hFEED_0001_FEED_0002});
		tx_busy_i = 1'b0;
		repeat (8) @(negedge clock_i);
		take_i = 1'b1;
		for (k = 0; k < 20 && repq.size() > 0; k++) @(negedge clock_i);
		rd(4'hC, SEL_CMD, 32'h0024_0019);
		tx_busy_i = 1'b1;
		frm(1'b0, 1'b1, 29'h2A5, 64'h0, 12, 1'b0, 1'b1);
		wr(4'hC, SEL_CMD, 32'h0000_0004);
		rd(4'hC, SEL_CMD, 32'h0024_0019);
		tx_busy_i = 1'b0;
		repeat (12) @(negedge clock_i);
		$display("Remote test done");
		chk_val(96'h0, 96'(rdq.size() + evq.size() + repq.size()));
		end_of_test();
	end
endmodule
`default_nettype wire
